// File: core/thermal_monitor_pkg.sv
package thermal_monitor_pkg;

	localparam int CLK_MHZ = 250;

	// Comparator debounce, both directions.
	localparam int  DEBOUNCE_US  = 10;
	localparam int  DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;

	// Duty-cycled sampling window and repeat interval.
	localparam int  WINDOW_US    = 450;
	localparam int  WINDOW_CYC   = WINDOW_US * CLK_MHZ;
	localparam real INTERVAL_MS  = 3.0;
	localparam int  INTERVAL_CYC = int'(INTERVAL_MS * 1000.0 * CLK_MHZ);

	localparam int NUM_WARN = 6;
	localparam int NUM_CMP  = 2 * NUM_WARN + 2;
	localparam int NUM_EVT  = NUM_WARN + 1;

	// Register byte offsets.
	localparam logic [11:0] CTRL_OFS   = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] MASK_OFS   = 12'h008;
	localparam logic [11:0] SENSE_OFS  = 12'h00c;

	// Field positions.
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_AON_BIT    = 1;
	localparam int EVT_SD_BIT      = 6;
	localparam int SENSE_SD_BIT    = 6;
	localparam int SENSE_POWER_BIT = 7;

	// Reset values.
	localparam logic        EN_RST   = 1'b1;
	localparam logic        AON_RST  = 1'b0;
	localparam logic [6:0]  MASK_RST = 7'h7f;

	typedef struct packed {
		logic [NUM_WARN-1:0] warn_trip;
		logic [NUM_WARN-1:0] warn_release;
		logic                sd_trip;
		logic                sd_release;
	} comparator_s;

	typedef struct packed {
		logic [11:0] cnt;
		logic        level;
	} debounce_state_s;

	typedef struct packed {
		logic [19:0] cnt;
		logic        power;
	} sampler_state_s;

	typedef struct packed {
		logic [NUM_CMP-1:0]  sync1;
		logic [NUM_CMP-1:0]  sync2;
		logic                en;
		logic                aon;
		logic [NUM_EVT-1:0]  flag;
		logic [NUM_EVT-1:0]  mask;
		logic [NUM_WARN-1:0] sense;
		logic                sd;
		logic [31:0]         prdata;
		logic                pready;
		logic                pslverr;
		logic                irq_n;
	} monitor_state_s;

endpackage

// File: core/comparator_debounce.sv
`timescale 1ns/1ps
module comparator_debounce
	import thermal_monitor_pkg::*;
#(
	parameter int DB_CYCLES = DEBOUNCE_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	input  wire logic raw,
	output logic      level
);

	initial begin
		if (DB_CYCLES < 1 || DB_CYCLES > 4095) begin
			$error("DB_CYCLES out of range");
		end
	end

	localparam logic [11:0] LAST = 12'(DB_CYCLES - 1);

	debounce_state_s s_q;
	debounce_state_s s_d;

	// A change is taken only after it has stood for the full count; any bounce restarts it.
	always_comb begin
		s_d = s_q;
		if (!run) begin
			s_d.cnt = 12'h000;
		end else if (raw == s_q.level) begin
			s_d.cnt = 12'h000;
		end else if (s_q.cnt == LAST) begin
			s_d.cnt   = 12'h000;
			s_d.level = raw;
		end else begin
			s_d.cnt = s_q.cnt + 12'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.level;

endmodule

// File: core/sample_scheduler.sv
`timescale 1ns/1ps
module sample_scheduler
	import thermal_monitor_pkg::*;
#(
	parameter int WIN_CYCLES = WINDOW_CYC,
	parameter int INT_CYCLES = INTERVAL_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic enable,
	input  wire logic always_on,
	input  wire logic standby,
	output logic      power_on
);

	initial begin
		if (WIN_CYCLES < 1 || WIN_CYCLES >= INT_CYCLES || INT_CYCLES > 1048576) begin
			$error("sampling window or interval out of range");
		end
	end

	localparam logic [19:0] WIN  = 20'(WIN_CYCLES);
	localparam logic [19:0] LAST = 20'(INT_CYCLES - 1);

	sampler_state_s s_q;
	sampler_state_s s_d;

	always_comb begin
		s_d = s_q;
		if (!enable) begin
			s_d.cnt   = 20'h00000;
			s_d.power = 1'b0;
		end else begin
			if (s_q.cnt == LAST) begin
				s_d.cnt = 20'h00000;
			end else begin
				s_d.cnt = s_q.cnt + 20'h00001;
			end
			if (always_on && !standby) begin
				s_d.power = 1'b1;
			end else begin
				s_d.power = (s_d.cnt < WIN);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign power_on = s_q.power;

endmodule

// File: core/thermal_monitor_control.sv
`timescale 1ns/1ps
module thermal_monitor_control
	import thermal_monitor_pkg::*;
#(
	parameter int DB_CYCLES  = DEBOUNCE_CYC,
	parameter int WIN_CYCLES = WINDOW_CYC,
	parameter int INT_CYCLES = INTERVAL_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire comparator_s centre_cmp,
	input  wire logic        standby_state,
	output logic             interrupt_out_n,
	output logic             thermal_shutdown_req,
	output logic             monitor_power_on
);

	localparam monitor_state_s RESET_STATE = '{
		sync1:   '0,
		sync2:   '0,
		en:      EN_RST,
		aon:     AON_RST,
		flag:    '0,
		mask:    MASK_RST,
		sense:   '0,
		sd:      1'b0,
		prdata:  32'h00000000,
		pready:  1'b0,
		pslverr: 1'b0,
		irq_n:   1'b1
	};

	monitor_state_s      s_q;
	monitor_state_s      s_d;
	logic [NUM_CMP-1:0]  db_level;
	logic                active;
	logic                setup_phase;
	logic                access_phase;
	logic                hit_ctrl;
	logic                hit_status;
	logic                hit_mask;
	logic                hit_sense;
	logic                hit_any;
	logic [NUM_WARN-1:0] warn_trip_db;
	logic [NUM_WARN-1:0] warn_release_db;
	logic                sd_trip_db;
	logic                sd_release_db;
	logic [NUM_EVT-1:0]  event_set;
	logic [31:0]         read_word;

	// Comparators are analog and asynchronous: each goes through two flops, then a debouncer.
	generate
		for (genvar i = 0; i < NUM_CMP; i++) begin : g_db
			comparator_debounce #(
				.DB_CYCLES (DB_CYCLES)
			) u_db (
				.pclk    (pclk),
				.presetn (presetn),
				.run     (active),
				.raw     (s_q.sync2[i]),
				.level   (db_level[i])
			);
		end
	endgenerate

	sample_scheduler #(
		.WIN_CYCLES (WIN_CYCLES),
		.INT_CYCLES (INT_CYCLES)
	) u_sched (
		.pclk      (pclk),
		.presetn   (presetn),
		.enable    (s_q.en),
		.always_on (s_q.aon),
		.standby   (standby_state),
		.power_on  (monitor_power_on)
	);

	// Comparators only mean something while enabled and powered.
	assign active = s_q.en & monitor_power_on;

	assign warn_trip_db    = db_level[NUM_CMP-1 -: NUM_WARN];
	assign warn_release_db = db_level[NUM_CMP-1-NUM_WARN -: NUM_WARN];
	assign sd_trip_db      = db_level[1];
	assign sd_release_db   = db_level[0];

	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable & s_q.pready;

	assign hit_ctrl   = (paddr == CTRL_OFS);
	assign hit_status = (paddr == STATUS_OFS);
	assign hit_mask   = (paddr == MASK_OFS);
	assign hit_sense  = (paddr == SENSE_OFS);
	assign hit_any    = hit_ctrl | hit_status | hit_mask | hit_sense;

	always_comb begin
		read_word = 32'h00000000;
		if (hit_ctrl) begin
			read_word[CTRL_EN_BIT]  = s_q.en;
			read_word[CTRL_AON_BIT] = s_q.aon;
		end else if (hit_status) begin
			read_word[NUM_EVT-1:0] = s_q.flag;
		end else if (hit_mask) begin
			read_word[NUM_EVT-1:0] = s_q.mask;
		end else if (hit_sense) begin
			read_word[NUM_WARN-1:0]   = s_q.sense;
			read_word[SENSE_SD_BIT]    = s_q.sd;
			read_word[SENSE_POWER_BIT] = monitor_power_on;
		end
	end

	always_comb begin
		s_d = s_q;
		event_set = '0;

		// Only the die-centre comparator set is wired in.
		s_d.sync1 = centre_cmp;
		s_d.sync2 = s_q.sync1;

		// Sense sets on the threshold comparator, releases on the one 5 C below.
		for (int i = 0; i < NUM_WARN; i++) begin
			if (active) begin
				if (warn_trip_db[i]) begin
					s_d.sense[i] = 1'b1;
				end else if (!warn_release_db[i]) begin
					s_d.sense[i] = 1'b0;
				end
			end
		end

		// Shutdown latches until the comparator 15 C below the trip point drops.
		if (active) begin
			if (sd_trip_db) begin
				s_d.sd = 1'b1;
			end else if (!sd_release_db) begin
				s_d.sd = 1'b0;
			end
		end

		event_set[NUM_WARN-1:0] = s_d.sense & ~s_q.sense & {NUM_WARN{active}};
		event_set[EVT_SD_BIT]   = s_d.sd & ~s_q.sd;

		// No wait state: the answer is prepared in setup and presented in the first access cycle.
		if (setup_phase) begin
			s_d.pready  = 1'b1;
			s_d.prdata  = pwrite ? 32'h00000000 : read_word;
			s_d.pslverr = ~hit_any;
		end else if (access_phase) begin
			s_d.pready  = 1'b0;
			s_d.prdata  = 32'h00000000;
			s_d.pslverr = 1'b0;
			if (pwrite) begin
				if (hit_ctrl) begin
					s_d.en  = pwdata[CTRL_EN_BIT];
					s_d.aon = pwdata[CTRL_AON_BIT];
				end
				if (hit_status) begin
					s_d.flag = s_q.flag & ~pwdata[NUM_EVT-1:0];
				end
				if (hit_mask) begin
					s_d.mask = pwdata[NUM_EVT-1:0];
				end
			end
		end

		// A new event beats a clear in the same cycle.
		s_d.flag = s_d.flag | event_set;

		s_d.irq_n = ~|(s_d.flag & ~s_d.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= RESET_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata               = s_q.prdata;
	assign pready               = s_q.pready;
	assign pslverr              = s_q.pslverr;
	assign interrupt_out_n      = s_q.irq_n;
	assign thermal_shutdown_req = s_q.sd;

endmodule

// File: verification/temp_comparator_model.sv
`timescale 1ns/1ps
module temp_comparator_model
	import thermal_monitor_pkg::*;
#(
	parameter int SD_C = 165
) (
	input  wire logic [7:0] temp_c,
	output comparator_s     cmp
);
	always_comb begin
		for (int i = 0; i < NUM_WARN; i++) begin
			cmp.warn_trip[i] = temp_c > 8'(80 + 15 * i);
			cmp.warn_release[i] = temp_c > 8'(75 + 15 * i);
		end
		cmp.sd_trip = temp_c > 8'(SD_C);
		cmp.sd_release = temp_c > 8'(SD_C - 15);
	end
endmodule

// File: verification/thermal_monitor_control_monitor.sv
`timescale 1ns/1ps
module thermal_monitor_control_monitor
	import thermal_monitor_pkg::*;
#(
	parameter int DB_CYCLES  = DEBOUNCE_CYC,
	parameter int WIN_CYCLES = WINDOW_CYC
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire comparator_s centre_cmp,
	input wire logic        standby_state,
	input wire logic        interrupt_out_n,
	input wire logic        thermal_shutdown_req,
	input wire logic        monitor_power_on
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [19:0] hi_q, lo_q, pw_q;
	logic        wr;
	assign wr = psel && penable && pready && pwrite;
	// Runs of consecutive input or output cycles, to bound timing.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= '0;
			lo_q <= '0;
			pw_q <= '0;
		end else begin
			hi_q <= centre_cmp.sd_trip ? hi_q + 20'h1 : '0;
			lo_q <= centre_cmp.sd_release ? '0 : lo_q + 20'h1;
			pw_q <= (monitor_power_on && standby_state) ? pw_q + 20'h1 : '0;
		end
	end
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_err_unmapped: assert property (pready && paddr > SENSE_OFS |-> pslverr)
		else $error("unmapped access without error");
	a_reset_idle: assert property ($rose(presetn) |-> interrupt_out_n && !thermal_shutdown_req)
		else $error("outputs active after reset");
	a_sd_debounce: assert property ($rose(thermal_shutdown_req) |-> hi_q >= DB_CYCLES)
		else $error("shutdown request before debounce");
	a_sd_release: assert property ($fell(thermal_shutdown_req) |-> lo_q >= DB_CYCLES)
		else $error("shutdown released while hot");
	a_disable_off: assert property (wr && paddr == CTRL_OFS && !pwdata[0] |=> ##[0:2] !monitor_power_on)
		else $error("monitor powered while disabled");
	a_aon_power: assert property (wr && paddr == CTRL_OFS && pwdata[1:0] == 2'h3 && !standby_state
		|=> ##[0:2] monitor_power_on)
		else $error("always on mode not powered");
	a_mask_all: assert property (wr && paddr == MASK_OFS && pwdata[6:0] == 7'h7f |=> ##[0:1] interrupt_out_n)
		else $error("interrupt while fully masked");
	a_standby_win: assert property (pw_q <= WIN_CYCLES + 1)
		else $error("standby window too long");
endmodule

bind thermal_monitor_control thermal_monitor_control_monitor #(.DB_CYCLES(DB_CYCLES), .WIN_CYCLES(WIN_CYCLES)) u_mon (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .centre_cmp,
	.standby_state, .interrupt_out_n, .thermal_shutdown_req, .monitor_power_on);

// File: verification/thermal_monitor_control_tb.sv
`timescale 1ns/1ps
module thermal_monitor_control_tb
	import thermal_monitor_pkg::*;
;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standby_state = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, interrupt_out_n, thermal_shutdown_req, monitor_power_on, er;
	logic [7:0]  temp_c = 8'h19;
	comparator_s centre_cmp;
	int          n_mismatch = 0, samples_checked = 0;

	temp_comparator_model u_sens (.temp_c, .cmp(centre_cmp));
	thermal_monitor_control #(.DB_CYCLES(4), .WIN_CYCLES(5), .INT_CYCLES(20)) u_dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .centre_cmp, .standby_state,
		.interrupt_out_n, .thermal_shutdown_req, .monitor_power_on);

	initial begin
		forever #2 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			n_mismatch++;
			finish_test();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(nm, rd, exp);
	endtask

	task automatic heat(input logic [7:0] t);
		temp_c <= t;
		repeat (12) @(posedge pclk);
	endtask

	task automatic duty(input logic [31:0] exp);
		int n;
		n = 0;
		repeat (4) @(posedge pclk);
		repeat (40) begin
			@(posedge pclk);
			n += monitor_power_on;
		end
		chk("power cycles", n, exp);
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		rdc("ctrl", CTRL_OFS, 32'h1);
		rdc("mask", MASK_OFS, 32'h7f);
		rdc("status", STATUS_OFS, 32'h0);
		rdc("unmapped", 12'h010, 32'h0);
		chk("slverr", er, 32'h1);
		$display("test reset done");
		wr(CTRL_OFS, 32'h3);
		wr(MASK_OFS, 32'h0);
		heat(8'h64);
		rdc("status", STATUS_OFS, 32'h3);
		rdc("sense", SENSE_OFS, 32'h83);
		chk("irq", interrupt_out_n, 32'h0);
		heat(8'h5c);
		rdc("sense", SENSE_OFS, 32'h83);
		heat(8'h58);
		rdc("sense", SENSE_OFS, 32'h81);
		wr(STATUS_OFS, 32'h1);
		rdc("status", STATUS_OFS, 32'h2);
		wr(MASK_OFS, 32'h2);
		@(posedge pclk);
		chk("irq", interrupt_out_n, 32'h1);
		wr(STATUS_OFS, 32'h2);
		wr(MASK_OFS, 32'h0);
		$display("test warning done");
		heat(8'haa);
		chk("sd", thermal_shutdown_req, 32'h1);
		rdc("status", STATUS_OFS, 32'h7e);
		chk("irq", interrupt_out_n, 32'h0);
		rdc("sense", SENSE_OFS, 32'hff);
		wr(MASK_OFS, 32'h7f);
		@(posedge pclk);
		chk("irq", interrupt_out_n, 32'h1);
		wr(MASK_OFS, 32'h0);
		heat(8'h9b);
		chk("sd", thermal_shutdown_req, 32'h1);
		heat(8'h8c);
		chk("sd", thermal_shutdown_req, 32'h0);
		wr(STATUS_OFS, 32'h7f);
		heat(8'h46);
		temp_c <= 8'h64;
		repeat (2) @(posedge pclk);
		heat(8'h46);
		rdc("status", STATUS_OFS, 32'h0);
		$display("test shutdown done");
		wr(CTRL_OFS, 32'h0);
		heat(8'h64);
		rdc("status", STATUS_OFS, 32'h0);
		duty(32'h0);
		wr(CTRL_OFS, 32'h3);
		heat(8'h64);
		rdc("status", STATUS_OFS, 32'h3);
		duty(32'h28);
		wr(CTRL_OFS, 32'h1);
		duty(32'ha);
		standby_state <= 1'h1;
		wr(CTRL_OFS, 32'h3);
		duty(32'ha);
		wr(CTRL_OFS, 32'h2);
		duty(32'h0);
		$display("test power done");
		finish_test();
	end
endmodule
